// ==== rtl/input_scan_sequencer.sv ====
// Summary of operation
// - hold 512-entry list of channel selections
// - convert entries in order, 1 us slot each
// - after last entry restart now or after delay
// - digital and counter capture uses no slot
// - host reads digital and counters any time
// - per-scan mode captures all in first slot
// - per-slot mode captures digital every slot
// - counters still captured only in first slot
// - 24 digital bits, four 32-bit counters, enables
// - thermocouple channels slow slot to 10 kHz
// - expansion addresses 64 single or 32 differential
// - per-channel gain range and input type applied
// - on-board 16 single-ended or 8 differential
`timescale 1ns/1ps
`default_nettype none
module input_scan_sequencer #(
  parameter int TC_SLOT_CYC = scan_pkg::TC_SLOT_CYC,
  parameter int DELAY_W = scan_pkg::DELAY_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // scan control
  input wire logic run,
  input wire logic repeat_delayed,
  input wire logic [DELAY_W-1:0] delay_steps,
  input wire logic [scan_pkg::LIST_AW:0] list_len,
  input wire logic expansion_present,
  input wire logic [1:0] sync_mode,
  input wire logic [scan_pkg::DIG_BITS-1:0] dig_en,
  input wire logic [scan_pkg::CNT_NUM-1:0] cnt_en,
  // scan list and channel configuration writes
  input wire logic list_wr,
  input wire logic [scan_pkg::LIST_AW-1:0] list_wr_addr,
  input wire logic [scan_pkg::CHAN_W-1:0] list_wr_chan,
  input wire logic cfg_wr,
  input wire logic [scan_pkg::CHAN_W-1:0] cfg_wr_chan,
  input wire logic [scan_pkg::GAIN_W-1:0] cfg_wr_gain,
  input wire logic cfg_wr_differential_input,
  input wire logic cfg_wr_thermocouple,
  // digital and counter inputs
  input wire logic [scan_pkg::DIG_BITS-1:0] din,
  input wire logic [scan_pkg::CNT_BITS-1:0] cnt_in [scan_pkg::CNT_NUM],
  // converter
  output logic conv_start_ff,
  output logic [scan_pkg::CHAN_W-1:0] conv_chan_ff,
  output logic [scan_pkg::GAIN_W-1:0] conv_gain_ff,
  output logic conv_differential_input_ff,
  input wire logic adc_valid,
  input wire logic [scan_pkg::ADC_BITS-1:0] adc_data,
  // result stream toward dma
  output logic out_valid_ff,
  output logic [2:0] out_kind_ff,
  output logic [scan_pkg::CNT_BITS-1:0] out_data_ff,
  // asynchronous read
  input wire logic rd_req,
  output logic rd_valid_ff,
  output logic [scan_pkg::DIG_BITS-1:0] rd_dig_ff,
  output logic [scan_pkg::CNT_BITS-1:0] rd_cnt_ff [scan_pkg::CNT_NUM],
  // status
  output logic busy_ff
);
  localparam int NCH = 1 << scan_pkg::CHAN_W;
  localparam logic [scan_pkg::SLOT_CNT_W-1:0] SLOT_LEN =
    scan_pkg::SLOT_CNT_W'(scan_pkg::SLOT_CYC);
  localparam logic [scan_pkg::SLOT_CNT_W-1:0] TC_LEN =
    scan_pkg::SLOT_CNT_W'(TC_SLOT_CYC);
  localparam logic [15:0] STEP_PS = 16'(scan_pkg::DELAY_STEP_PS);
  localparam logic [15:0] CLK_PS = 16'(scan_pkg::CLK_PERIOD_PS);

  logic [scan_pkg::CHAN_W-1:0] list_mem [scan_pkg::LIST_DEPTH];
  logic [scan_pkg::GAIN_W-1:0] gain_mem [NCH];
  logic diff_mem [NCH];
  logic tc_mem [NCH];
  scan_pkg::seq_state_t state_ff, nxt_state;
  logic [scan_pkg::LIST_AW-1:0] idx_ff, nxt_idx;
  logic [scan_pkg::SLOT_CNT_W-1:0] slot_cnt_ff, slot_len_ff;
  logic [DELAY_W-1:0] delay_cnt_ff;
  logic [15:0] step_acc_ff;
  logic step_tick, slot_end, last_entry, go;
  logic [scan_pkg::LIST_AW-1:0] last_idx;
  logic [scan_pkg::CHAN_W-1:0] nxt_chan;
  logic cap_pulse_ff, cap_first_ff, dig_cap_en_ff;
  logic word_valid;
  logic [2:0] word_kind;
  logic [scan_pkg::CNT_BITS-1:0] word_data;
  logic adc_pend_ff;
  logic [scan_pkg::ADC_BITS-1:0] adc_hold_ff;

  // fold a selection into the channels that exist for this setup
  function automatic logic [scan_pkg::CHAN_W-1:0] legal_chan(
    input logic [scan_pkg::CHAN_W-1:0] ch, input logic exp,
    input logic diff);
    int lim;
    lim = exp ? (diff ? scan_pkg::DIF_EXP : scan_pkg::SGL_EXP)
              : (diff ? scan_pkg::DIF_BASE : scan_pkg::SGL_BASE);
    return ch & scan_pkg::CHAN_W'(lim - 1);
  endfunction

  // host writes to the list and per-channel tables
  always_ff @(posedge clock) begin
    if (list_wr) list_mem[list_wr_addr] <= list_wr_chan;
    if (cfg_wr) begin
      gain_mem[cfg_wr_chan] <= (cfg_wr_gain > scan_pkg::GAIN_MAX) ?
                               scan_pkg::GAIN_MAX : cfg_wr_gain;
      diff_mem[cfg_wr_chan] <= cfg_wr_differential_input;
      tc_mem[cfg_wr_chan] <= cfg_wr_thermocouple;
    end
  end

  // an empty list length is treated as one entry
  assign last_idx = (list_len == '0) ? '0 :
                    scan_pkg::LIST_AW'(list_len - 1'b1);
  assign last_entry = idx_ff == last_idx;
  assign slot_end = state_ff == scan_pkg::ST_SLOT &&
                    slot_cnt_ff == slot_len_ff - 1'b1;
  assign nxt_chan = list_mem[nxt_idx];

  // sequencing decisions; go marks the start of a new slot
  always_comb begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    go = 1'b0;
    unique case (state_ff)
      scan_pkg::ST_IDLE: begin
        if (run) begin
          go = 1'b1;
          nxt_idx = '0;
        end
      end
      scan_pkg::ST_SLOT: begin
        if (slot_end) begin
          if (!last_entry) begin
            go = 1'b1;
            nxt_idx = idx_ff + 1'b1;
          end else if (!run) begin
            nxt_state = scan_pkg::ST_IDLE;
          end else if (repeat_delayed && delay_steps != '0) begin
            nxt_state = scan_pkg::ST_GAP;
          end else begin
            go = 1'b1;
            nxt_idx = '0;
          end
        end
      end
      scan_pkg::ST_GAP: begin
        if (!run) begin
          nxt_state = scan_pkg::ST_IDLE;
        end else if (step_tick && delay_cnt_ff == DELAY_W'(1)) begin
          go = 1'b1;
          nxt_idx = '0;
        end
      end
    endcase
    if (go) nxt_state = scan_pkg::ST_SLOT;
  end

  // state, index and slot timing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= scan_pkg::ST_IDLE;
      idx_ff <= '0;
      slot_cnt_ff <= '0;
      slot_len_ff <= SLOT_LEN;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      if (go) begin
        slot_cnt_ff <= '0;
        // thermocouple channels need the long slot
        slot_len_ff <= tc_mem[nxt_chan] ? TC_LEN : SLOT_LEN;
      end else if (state_ff == scan_pkg::ST_SLOT) begin
        slot_cnt_ff <= slot_cnt_ff + 1'b1;
      end
    end
  end

  // 20.83 ns steps from a 4 ns clock by a picosecond accumulator;
  // steps jitter by one clock but never drift
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      step_acc_ff <= '0;
      delay_cnt_ff <= '0;
    end else if (state_ff != scan_pkg::ST_GAP) begin
      step_acc_ff <= '0;
      delay_cnt_ff <= delay_steps;
    end else begin
      step_acc_ff <= step_tick ? step_acc_ff + CLK_PS - STEP_PS
                               : step_acc_ff + CLK_PS;
      if (step_tick) delay_cnt_ff <= delay_cnt_ff - 1'b1;
    end
  end
  assign step_tick = step_acc_ff + CLK_PS >= STEP_PS;

  // converter request, channel settings applied per slot
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      conv_start_ff <= 1'b0;
      conv_chan_ff <= '0;
      conv_gain_ff <= '0;
      conv_differential_input_ff <= 1'b0;
    end else begin
      conv_start_ff <= go;
      if (go) begin
        conv_chan_ff <= legal_chan(nxt_chan, expansion_present,
                                   diff_mem[nxt_chan]);
        conv_gain_ff <= gain_mem[nxt_chan];
        conv_differential_input_ff <= diff_mem[nxt_chan];
      end
    end
  end

  // capture rides on the slot start, so it never adds a slot
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cap_pulse_ff <= 1'b0;
      cap_first_ff <= 1'b0;
      dig_cap_en_ff <= 1'b0;
    end else begin
      cap_first_ff <= go && nxt_idx == '0;
      unique case (sync_mode)
        scan_pkg::SYNC_PER_SCAN: begin
          cap_pulse_ff <= go && nxt_idx == '0;
          dig_cap_en_ff <= 1'b1;
        end
        scan_pkg::SYNC_PER_SLOT: begin
          cap_pulse_ff <= go;
          dig_cap_en_ff <= 1'b1;
        end
        default: begin
          cap_pulse_ff <= 1'b0;
          dig_cap_en_ff <= 1'b0;
        end
      endcase
    end
  end

  capture_serializer u_capture (
    .clock(clock),
    .rst(rst),
    .cap_pulse(cap_pulse_ff),
    .cap_first(cap_first_ff),
    .dig_cap_en(dig_cap_en_ff),
    .dig_en(dig_en),
    .cnt_en(cnt_en),
    .din(din),
    .cnt_in(cnt_in),
    .word_valid(word_valid),
    .word_kind(word_kind),
    .word_data(word_data)
  );

  // analog result waits while captured words drain; a new result wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      adc_pend_ff <= 1'b0;
      adc_hold_ff <= '0;
    end else if (adc_valid) begin
      adc_pend_ff <= 1'b1;
      adc_hold_ff <= adc_data;
    end else if (!word_valid) begin
      adc_pend_ff <= 1'b0;
    end
  end

  // stream mux, captured words first
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_valid_ff <= 1'b0;
      out_kind_ff <= scan_pkg::KIND_ANALOG;
      out_data_ff <= '0;
    end else if (word_valid) begin
      out_valid_ff <= 1'b1;
      out_kind_ff <= word_kind;
      out_data_ff <= word_data;
    end else begin
      out_valid_ff <= adc_pend_ff;
      out_kind_ff <= scan_pkg::KIND_ANALOG;
      out_data_ff <= {{(scan_pkg::CNT_BITS-scan_pkg::ADC_BITS){1'b0}},
                      adc_hold_ff};
    end
  end

  // on-demand read, untied to the scan
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_valid_ff <= 1'b0;
      rd_dig_ff <= '0;
      for (int i = 0; i < scan_pkg::CNT_NUM; i++) rd_cnt_ff[i] <= '0;
    end else begin
      rd_valid_ff <= rd_req;
      if (rd_req) begin
        rd_dig_ff <= din;
        for (int i = 0; i < scan_pkg::CNT_NUM; i++) rd_cnt_ff[i] <= cnt_in[i];
      end
    end
  end

  // busy while a scan or its repeat delay runs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) busy_ff <= 1'b0;
    else busy_ff <= nxt_state != scan_pkg::ST_IDLE;
  end

  // helper: spacing and index of consecutive slot starts
  logic [scan_pkg::SLOT_CNT_W-1:0] since_ff, prev_len_ff;
  logic [scan_pkg::LIST_AW-1:0] prev_idx_ff;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      since_ff <= '0;
      prev_len_ff <= '0;
      prev_idx_ff <= '0;
    end else if (conv_start_ff) begin
      since_ff <= 16'h0001;
      prev_len_ff <= slot_len_ff;
      prev_idx_ff <= idx_ff;
    end else if (since_ff != 16'hffff) begin
      since_ff <= since_ff + 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_slot_spacing: assert property (
    conv_start_ff && idx_ff != '0 |-> since_ff == prev_len_ff)
    else $error("slot start not one slot after previous");
  chk_list_order: assert property (
    conv_start_ff && idx_ff != '0 |-> idx_ff == prev_idx_ff + 1'b1)
    else $error("list entry skipped or repeated");
  chk_quick_restart: assert property (
    slot_end && last_entry && run && !repeat_delayed
    |=> conv_start_ff && idx_ff == '0)
    else $error("list did not restart at once");
  chk_scan_capture: assert property (
    conv_start_ff && idx_ff == '0 && sync_mode == scan_pkg::SYNC_PER_SCAN
    |-> cap_pulse_ff && cap_first_ff)
    else $error("first-slot capture missing");
  chk_slot_capture: assert property (
    conv_start_ff && sync_mode == scan_pkg::SYNC_PER_SLOT |-> cap_pulse_ff)
    else $error("per-slot digital capture missing");
  chk_counter_first: assert property (
    cap_pulse_ff |-> cap_first_ff == (idx_ff == '0))
    else $error("counter capture outside first slot");
  chk_async_read: assert property (
    rd_req |=> rd_valid_ff && rd_dig_ff == $past(din))
    else $error("on-demand read wrong");
  chk_chan_legal: assert property (
    conv_start_ff && !expansion_present |-> conv_chan_ff < 6'h10)
    else $error("channel beyond on-board range");
  chk_gain_apply: assert property (
    conv_start_ff |-> conv_gain_ff == gain_mem[list_mem[idx_ff]])
    else $error("channel gain not applied");
  chk_tc_slot: assert property (
    conv_start_ff && tc_mem[list_mem[idx_ff]] |-> slot_len_ff == TC_LEN)
    else $error("thermocouple slot too short");
  chk_words_first: assert property (
    word_valid |=> out_valid_ff && out_kind_ff != scan_pkg::KIND_ANALOG)
    else $error("analog result ahead of captured words");

  cov_delayed_repeat: cover property (
    state_ff == scan_pkg::ST_GAP ##1 conv_start_ff);
  cov_per_slot: cover property (
    cap_pulse_ff && !cap_first_ff);
  cov_counter_word: cover property (
    out_valid_ff && out_kind_ff == scan_pkg::KIND_CNT_BASE);
endmodule
`default_nettype wire

// ==== rtl/scan_pkg.sv ====
`default_nettype none
package scan_pkg;
  // list and channel geometry
  localparam int LIST_DEPTH = 512;
  localparam int LIST_AW = 9;
  localparam int CHAN_W = 6;
  localparam int SGL_BASE = 16;
  localparam int DIF_BASE = 8;
  localparam int SGL_EXP = 64;
  localparam int DIF_EXP = 32;
  localparam int GAIN_W = 3;
  localparam logic [2:0] GAIN_MAX = 3'h6;  // seven ranges, codes 0..6
  localparam int DIG_BITS = 24;
  localparam int CNT_NUM = 4;
  localparam int CNT_BITS = 32;
  localparam int ADC_BITS = 16;
  // timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SLOT_TIME_NS = 1000;
  localparam int SLOT_CYC =
    (SLOT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TC_RATE_HZ = 10000;
  localparam int TC_SLOT_NS = 1000000000 / TC_RATE_HZ;
  localparam int TC_SLOT_CYC =
    (TC_SLOT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DELAY_STEP_PS = 20830;
  localparam int DELAY_MAX_HOURS = 19;
  localparam int DELAY_W = 42;  // covers 19 h in 20.83 ns steps
  localparam int SLOT_CNT_W = 16;
  // output word kinds
  localparam logic [2:0] KIND_ANALOG = 3'h0;
  localparam logic [2:0] KIND_DIGITAL = 3'h1;
  localparam logic [2:0] KIND_CNT_BASE = 3'h2;  // counter n is base + n
  typedef enum logic [1:0] {SYNC_OFF, SYNC_PER_SCAN, SYNC_PER_SLOT} sync_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SLOT, ST_GAP} seq_state_t;
endpackage
`default_nettype wire

// ==== rtl/capture_serializer.sv ====
`timescale 1ns/1ps
`default_nettype none
module capture_serializer (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // capture request
  input wire logic cap_pulse,
  input wire logic cap_first,
  input wire logic dig_cap_en,
  input wire logic [scan_pkg::DIG_BITS-1:0] dig_en,
  input wire logic [scan_pkg::CNT_NUM-1:0] cnt_en,
  // sampled inputs
  input wire logic [scan_pkg::DIG_BITS-1:0] din,
  input wire logic [scan_pkg::CNT_BITS-1:0] cnt_in [scan_pkg::CNT_NUM],
  // serial word stream, one word a cycle, lowest pending first
  output logic word_valid,
  output logic [2:0] word_kind,
  output logic [scan_pkg::CNT_BITS-1:0] word_data
);
  logic [scan_pkg::DIG_BITS-1:0] dig_ff;
  logic [scan_pkg::CNT_BITS-1:0] cnt_ff [scan_pkg::CNT_NUM];
  logic [scan_pkg::CNT_NUM:0] pend_ff;
  logic [scan_pkg::CNT_NUM:0] sel;

  // digital every capture, counters only on the first slot
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dig_ff <= '0;
      for (int i = 0; i < scan_pkg::CNT_NUM; i++) cnt_ff[i] <= '0;
    end else if (cap_pulse) begin
      dig_ff <= din & dig_en;
      if (cap_first) begin
        for (int i = 0; i < scan_pkg::CNT_NUM; i++) begin
          if (cnt_en[i]) cnt_ff[i] <= cnt_in[i];
        end
      end
    end
  end

  // lowest set pending bit goes out this cycle
  always_comb begin
    sel = '0;
    word_kind = scan_pkg::KIND_DIGITAL;
    word_data = '0;
    if (pend_ff[0]) begin
      sel[0] = 1'b1;
      word_data = {{(scan_pkg::CNT_BITS-scan_pkg::DIG_BITS){1'b0}}, dig_ff};
    end else begin
      for (int i = scan_pkg::CNT_NUM - 1; i >= 0; i--) begin
        if (pend_ff[i+1]) begin
          sel = '0;
          sel[i+1] = 1'b1;
          word_kind = scan_pkg::KIND_CNT_BASE + 3'(i);
          word_data = cnt_ff[i];
        end
      end
    end
  end
  assign word_valid = |pend_ff;

  // pending set by a capture, cleared as each word leaves
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_ff <= '0;
    end else if (cap_pulse) begin
      pend_ff <= {(cap_first ? cnt_en : {scan_pkg::CNT_NUM{1'b0}}),
                  dig_cap_en && (|dig_en)};
    end else begin
      pend_ff <= pend_ff & ~sel;
    end
  end
endmodule
`default_nettype wire

// ==== tb/adc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// converter stand-in: answers each start after a short or a long latency
module adc_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // conversion request
  input wire logic conv_start,
  input wire logic [scan_pkg::CHAN_W-1:0] chan,
  input wire logic [scan_pkg::GAIN_W-1:0] gain,
  input wire logic diff,
  input wire logic slow,
  // result
  output logic adc_valid,
  output logic [scan_pkg::ADC_BITS-1:0] adc_data
);
  logic [3:0] wait_ff;
  logic pend_ff;
  logic [scan_pkg::ADC_BITS-1:0] hold_ff;
  // result encodes the slot settings so the bench can tell slots apart;
  // between results the data lines flip so a stale value never matches
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      adc_valid <= 1'b0;
      adc_data <= 16'h0000;
      wait_ff <= 4'h0;
      pend_ff <= 1'b0;
      hold_ff <= 16'h0000;
    end else begin
      adc_valid <= 1'b0;
      adc_data <= ~adc_data;
      if (conv_start) begin
        pend_ff <= 1'b1;
        wait_ff <= slow ? 4'hb : 4'h1;  // never answers in the start cycle
        hold_ff <= {6'h2a, diff, gain, chan};
      end else if (pend_ff) begin
        if (wait_ff == 4'h0) begin
          pend_ff <= 1'b0;
          adc_valid <= 1'b1;
          adc_data <= hold_ff;
        end else begin
          wait_ff <= wait_ff - 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int TC = 20;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic run, repeat_delayed, expansion_present, list_wr, cfg_wr, slow;
  logic [scan_pkg::DELAY_W-1:0] delay_steps;
  logic [scan_pkg::LIST_AW:0] list_len;
  logic [1:0] sync_mode;
  logic [23:0] dig_en, din, rd_dig_ff;
  logic [3:0] cnt_en;
  logic [8:0] list_wr_addr;
  logic [5:0] list_wr_chan, cfg_wr_chan, conv_chan_ff;
  logic [2:0] cfg_wr_gain, conv_gain_ff, out_kind_ff;
  logic cfg_wr_differential_input, cfg_wr_thermocouple;
  logic [31:0] cnt_in [4];
  logic [31:0] rd_cnt_ff [4];
  logic conv_start_ff, conv_differential_input_ff, adc_valid, out_valid_ff;
  logic [15:0] adc_data;
  logic [31:0] out_data_ff;
  logic rd_req, rd_valid_ff, busy_ff;
  int n_fail = 0;
  int n_compared = 0;
  int cyc = 0;
  int t_q[$];
  logic [9:0] s_q[$];
  logic [23:0] d_q[$];
  logic [127:0] c_q[$];
  logic [34:0] w_q[$];
  logic [5:0] l_ch [512];
  logic [2:0] g_of [64];
  logic d_of [64];
  logic tc_of [64];

  always #2 clock = ~clock;

  input_scan_sequencer #(.TC_SLOT_CYC(TC)) dut (.clock(clock), .rst(rst),
    .run(run), .repeat_delayed(repeat_delayed), .delay_steps(delay_steps),
    .list_len(list_len), .expansion_present(expansion_present),
    .sync_mode(sync_mode), .dig_en(dig_en), .cnt_en(cnt_en),
    .list_wr(list_wr), .list_wr_addr(list_wr_addr),
    .list_wr_chan(list_wr_chan), .cfg_wr(cfg_wr), .cfg_wr_chan(cfg_wr_chan),
    .cfg_wr_gain(cfg_wr_gain),
    .cfg_wr_differential_input(cfg_wr_differential_input),
    .cfg_wr_thermocouple(cfg_wr_thermocouple), .din(din), .cnt_in(cnt_in),
    .conv_start_ff(conv_start_ff), .conv_chan_ff(conv_chan_ff),
    .conv_gain_ff(conv_gain_ff),
    .conv_differential_input_ff(conv_differential_input_ff),
    .adc_valid(adc_valid), .adc_data(adc_data), .out_valid_ff(out_valid_ff),
    .out_kind_ff(out_kind_ff), .out_data_ff(out_data_ff), .rd_req(rd_req),
    .rd_valid_ff(rd_valid_ff), .rd_dig_ff(rd_dig_ff), .rd_cnt_ff(rd_cnt_ff),
    .busy_ff(busy_ff));

  adc_model adc (.clock(clock), .rst(rst), .conv_start(conv_start_ff),
    .chan(conv_chan_ff), .gain(conv_gain_ff),
    .diff(conv_differential_input_ff), .slow(slow),
    .adc_valid(adc_valid), .adc_data(adc_data));

  // monitor: log each slot start with the inputs the capture sees, then
  // move the inputs so a capture taken in the wrong slot shows up
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (conv_start_ff === 1'b1) begin
      t_q.push_back(cyc);
      s_q.push_back({conv_differential_input_ff, conv_gain_ff, conv_chan_ff});
      d_q.push_back(din);
      c_q.push_back({cnt_in[3], cnt_in[2], cnt_in[1], cnt_in[0]});
      din <= din + 24'h010101;
      for (int i = 0; i < 4; i++) cnt_in[i] <= cnt_in[i] + 32'h1;
    end
    if (out_valid_ff === 1'b1) w_q.push_back({out_kind_ff, out_data_ff});
  end

  task automatic end_of_test();
    $display("n_fail=%0d n_compared=%0d", n_fail, n_compared);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_list(input int a, input logic [5:0] ch);
    @(posedge clock);
    list_wr <= 1'b1;
    list_wr_addr <= a[8:0];
    list_wr_chan <= ch;
    l_ch[a] = ch;
    @(posedge clock);
    list_wr <= 1'b0;
  endtask

  task automatic wr_cfg(input logic [5:0] ch, input logic [2:0] g,
                        input logic df, input logic tc);
    @(posedge clock);
    cfg_wr <= 1'b1;
    cfg_wr_chan <= ch;
    cfg_wr_gain <= g;
    cfg_wr_differential_input <= df;
    cfg_wr_thermocouple <= tc;
    {g_of[ch], d_of[ch], tc_of[ch]} = {g, df, tc};
    @(posedge clock);
    cfg_wr <= 1'b0;
  endtask

  // on-demand read: answer one cycle later with the inputs of the request
  task automatic rd_chk();
    logic [23:0] ed;
    logic [127:0] ec;
    @(posedge clock);
    rd_req <= 1'b1;
    @(posedge clock);
    ed = din;
    ec = {cnt_in[3], cnt_in[2], cnt_in[1], cnt_in[0]};
    rd_req <= 1'b0;
    #1;
    chk(rd_valid_ff, 1'b1);
    chk(rd_dig_ff, ed);
    for (int i = 0; i < 4; i++) chk(rd_cnt_ff[i], ec[32*i+:32]);
  endtask

  // run n slots, then check slot spacing, settings and the word stream
  task automatic scan(input int n, input int len, input logic [1:0] mode,
                      input bit rd);
    int k, s, p, d, lo;
    logic [5:0] ch, ec;
    logic [34:0] e_q[$];
    t_q.delete(); s_q.delete(); d_q.delete(); c_q.delete(); w_q.delete();
    @(posedge clock);
    run <= 1'b1;
    if (rd) rd_chk();
    k = 0;
    while (t_q.size() < n && k < 20000) begin
      @(posedge clock);
      k++;
    end
    run <= 1'b0;
    if (k == 20000) begin
      n_fail++;
      end_of_test();
    end
    chk(busy_ff, 1'b1);
    for (k = 0; k < n; k++) begin
      s = k % len;
      ch = l_ch[s];
      // out-of-range selections fold onto the channels that exist
      ec = ch & (expansion_present ? (d_of[ch] ? 6'h1f : 6'h3f)
                                   : (d_of[ch] ? 6'h07 : 6'h0f));
      chk(s_q[k], {d_of[ch], g_of[ch], ec});
      if ((s == 0 && mode != 2'd0) || mode == 2'd2) begin
        if (dig_en != 24'h0)
          e_q.push_back({scan_pkg::KIND_DIGITAL, 8'h00, d_q[k] & dig_en});
      end
      if (s == 0 && mode != 2'd0) begin
        for (int i = 0; i < 4; i++)
          if (cnt_en[i]) e_q.push_back({scan_pkg::KIND_CNT_BASE + 3'(i),
                                        c_q[k][32*i+:32]});
      end
      e_q.push_back({scan_pkg::KIND_ANALOG, 16'h0, 6'h2a, d_of[ch],
                     g_of[ch], ec});
      if (k > 0) begin
        p = (k - 1) % len;
        d = t_q[k] - t_q[k-1];
        lo = tc_of[l_ch[p]] ? TC : 250;
        if (p == len - 1 && repeat_delayed)
          chk(d >= lo + 46 && d <= lo + 58, 1'b1);
        else
          chk(d, lo);
      end
    end
    k = 0;
    while ((busy_ff !== 1'b0 || w_q.size() < e_q.size()) && k < 2000) begin
      @(posedge clock);
      k++;
    end
    if (k == 2000) begin
      n_fail++;
      end_of_test();
    end
    chk(w_q.size(), e_q.size());
    for (k = 0; k < e_q.size() && k < w_q.size(); k++)
      chk(w_q[k], e_q[k]);
  endtask

  initial begin
    {run, repeat_delayed, expansion_present, list_wr, cfg_wr, slow} = 6'h0;
    {delay_steps, list_len, sync_mode, dig_en, cnt_en} = '0;
    {list_wr_addr, list_wr_chan, cfg_wr_chan, cfg_wr_gain} = '0;
    {cfg_wr_differential_input, cfg_wr_thermocouple, rd_req} = 3'h0;
    din = 24'h5a0f3c;
    for (int i = 0; i < 4; i++) cnt_in[i] = 32'h10000000 * (i + 1) + 32'h7;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chk({conv_start_ff, out_valid_ff, rd_valid_ff, busy_ff}, 4'h0);
    // channel table: differential, wide gain, expansion and slow channels
    wr_cfg(6'd5, 3'h6, 1'b1, 1'b0);
    wr_cfg(6'd40, 3'h2, 1'b0, 1'b0);
    wr_cfg(6'd12, 3'h0, 1'b0, 1'b0);
    wr_cfg(6'd20, 3'h3, 1'b0, 1'b1);
    wr_cfg(6'd3, 3'h1, 1'b1, 1'b0);
    wr_list(0, 6'd5);
    wr_list(1, 6'd40);
    wr_list(2, 6'd12);
    @(posedge clock);
    expansion_present <= 1'b1;
    list_len <= 10'd3;
    sync_mode <= 2'd1;
    dig_en <= 24'hffffff;
    cnt_en <= 4'hf;
    rd_chk();
    // once per scan, two scans back to back with an on-demand read inside
    scan(6, 3, 2'd1, 1'b1);
    // per slot with partial enables and a slow converter
    @(posedge clock);
    sync_mode <= 2'd2;
    dig_en <= 24'h00ff0f;
    cnt_en <= 4'h5;
    slow <= 1'b1;
    scan(3, 3, 2'd2, 1'b0);
    // capture off, on-board range only, thermocouple slot, delayed restart;
    // channel 20 has no on-board home and folds onto channel 4
    wr_list(0, 6'd20);
    wr_list(1, 6'd3);
    @(posedge clock);
    list_len <= 10'd2;
    expansion_present <= 1'b0;
    sync_mode <= 2'd0;
    slow <= 1'b0;
    repeat_delayed <= 1'b1;
    delay_steps <= 42'd10;
    scan(4, 2, 2'd0, 1'b0);
    rd_chk();
    end_of_test();
  end
endmodule
`default_nettype wire
